/* rtl/pdsc_params.svh */
`ifndef PDSC_PARAMS_SVH
`define PDSC_PARAMS_SVH

`define PDSC_ADDR_W       8
`define PDSC_OFF_CTRL     8'h00
`define PDSC_OFF_CMP_EN   8'h04
`define PDSC_OFF_PULLUP   8'h08
`define PDSC_OFF_PULLDN   8'h0C
`define PDSC_OFF_BC_SW    8'h10
`define PDSC_OFF_STATUS   8'h14
`define PDSC_OFF_IRQ_STAT 8'h18
`define PDSC_OFF_IRQ_MASK 8'h1C

`define PDSC_CTRL_EP_EN   0
`define PDSC_CTRL_DCD_EN  1
`define PDSC_CTRL_CHG_EN  2
`define PDSC_CTRL_SBU_EN  3
`define PDSC_CTRL_USB_EN  4
`define PDSC_CTRL_W       5

`define PDSC_NPIN         6
`define PDSC_PIN_SBU1     0
`define PDSC_PIN_SBU2     1
`define PDSC_PIN_TP       2
`define PDSC_PIN_TN       3
`define PDSC_PIN_BP       4
`define PDSC_PIN_BN       5

`define PDSC_BC_FORCE_LSB 0
`define PDSC_BC_SINK_LSB  4
`define PDSC_BC_READ_LSB  8
`define PDSC_BC_W         12
`define PDSC_BC_FLD_W     4

`define PDSC_STAT_ORIENT  0
`define PDSC_STAT_TX      1
`define PDSC_STAT_PIN_LSB 8

`define PDSC_RST_CTRL     5'h00
`define PDSC_RST_PINS     6'h00
`define PDSC_RST_BC       12'h000
`define PDSC_EP_ZERO      4'h0
`define PDSC_BILLBOARD    8'h11
`define PDSC_BC_IDLE      4'h0
`define PDSC_CLASS_IDLE   8'h00

`endif

/* rtl/pdsc_pkg.sv */
package pdsc_pkg;

  typedef enum logic
  {
    PDSC_UPSIDE_UP,
    PDSC_FLIPPED
  } pdsc_orient_t;

  typedef logic [5:0] pdsc_pins_t;
  typedef logic [3:0] pdsc_usb_t;

endpackage

/* rtl/pdsc_top.sv */
// The placing of the registers and register access over APB were decided locally.
`timescale 1ns/1ps
`include "pdsc_params.svh"

module pdsc_top
(
  // Clock and reset.
  input  wire logic                   sys_clk_i,
  input  wire logic                   arst_n_i,
  // APB slave.
  input  wire logic                   psel_i,
  input  wire logic                   penable_i,
  input  wire logic                   pwrite_i,
  input  wire logic [31:0]            paddr_i,
  input  wire logic [31:0]            pwdata_i,
  output logic                        pready_o,
  output logic                        pslverr_o,
  output logic [31:0]                 prdata_o,
  output logic                        irq_o,
  // Cable orientation.
  input  wire pdsc_pkg::pdsc_orient_t orient_i,
  // Port pins: sideband one, two, top D+, D-, bottom D+, D-.
  input  wire pdsc_pkg::pdsc_pins_t   port_in_i,
  output pdsc_pkg::pdsc_pins_t        port_out_o,
  output pdsc_pkg::pdsc_pins_t        port_oe_o,
  output pdsc_pkg::pdsc_pins_t        clamp_en_o,
  output pdsc_pkg::pdsc_pins_t        pullup_en_o,
  output pdsc_pkg::pdsc_pins_t        pulldown_en_o,
  // System-side sideband pair.
  input  wire logic                   sb_a_i,
  input  wire logic                   sb_b_i,
  input  wire logic                   sb_oe_i,
  output logic                        sb_a_o,
  output logic                        sb_b_o,
  // Low-speed endpoint transceiver.
  input  wire logic                   ep_tx_i,
  input  wire logic                   ep_dp_i,
  input  wire logic                   ep_dm_i,
  input  wire logic                   ep_tok_vld_i,
  input  wire logic [3:0]             ep_tok_num_i,
  output logic                        ep_dp_o,
  output logic                        ep_dm_o,
  output logic                        ep_tok_ok_o,
  output logic                        ep_low_speed_o,
  output logic [7:0]                  ep_dev_class_o,
  output logic                        endpoint_pullup_top_o,
  output logic                        endpoint_pullup_bottom_o,
  // Charger detection.
  output logic                        dplus_source_current_top_o,
  output logic                        dplus_source_current_bottom_o,
  output logic                        dminus_pulldown_top_o,
  output logic                        dminus_pulldown_bottom_o,
  output logic                        detect_voltage_source_o,
  output logic                        detect_current_sink_o,
  output pdsc_pkg::pdsc_usb_t         bc_force_o,
  output pdsc_pkg::pdsc_usb_t         bc_sink_o,
  output pdsc_pkg::pdsc_usb_t         bc_read_o
);
  import pdsc_pkg::*;

  // Software registers and interrupt state.
  logic [`PDSC_CTRL_W-1:0] ctrl_q;
  pdsc_pins_t              cmp_en_q;
  pdsc_pins_t              pullup_q;
  pdsc_pins_t              pulldn_q;
  logic [`PDSC_BC_W-1:0]   bc_q;
  pdsc_pins_t              irq_stat_q;
  pdsc_pins_t              irq_stat_d;
  pdsc_pins_t              irq_mask_q;
  // Sampled pins, orientation and path gates.
  pdsc_pins_t              pin_q;
  pdsc_pins_t              edge_evt;
  pdsc_orient_t            orient_q;
  logic                    flip;
  logic                    blank;
  logic                    ep_en;
  logic                    usb_on;
  logic                    sbu_on;
  logic                    top_on;
  logic                    bot_on;
  logic                    tx_on;
  logic                    rx_pu;
  logic                    dcd_on;
  logic                    chg_on;
  // Bus decode.
  logic                    setup;
  logic                    acc;
  logic                    wr;
  logic                    rd;
  logic                    hit;
  logic [`PDSC_ADDR_W-1:0] addr;
  logic [31:0]             rdata;
  // Next pin drive values and read-clear control.
  pdsc_pins_t              out_d;
  pdsc_pins_t              oe_d;
  pdsc_pins_t              closed;
  pdsc_pins_t              stat_shown;
  logic                    stat_clr;

  // APB: one wait state; pready rises the cycle after penable.
  assign setup = psel_i & penable_i & ~pready_o;
  assign acc   = psel_i & penable_i & pready_o;
  assign addr  = paddr_i[`PDSC_ADDR_W-1:0];
  // Only aligned offsets up to the mask register answer without error.
  assign hit   = (paddr_i[31:`PDSC_ADDR_W] == '0) & (addr[1:0] == 2'h0)
               & (addr <= `PDSC_OFF_IRQ_MASK);
  assign wr    = acc & pwrite_i & ~pslverr_o;
  assign rd    = acc & ~pwrite_i & ~pslverr_o;

  // Unused bits read as zero.
  always_comb
  begin
    rdata = '0;
    unique case (addr)
      `PDSC_OFF_CTRL:     rdata[`PDSC_CTRL_W-1:0] = ctrl_q;
      `PDSC_OFF_CMP_EN:   rdata[`PDSC_NPIN-1:0] = cmp_en_q;
      `PDSC_OFF_PULLUP:   rdata[`PDSC_NPIN-1:0] = pullup_q;
      `PDSC_OFF_PULLDN:   rdata[`PDSC_NPIN-1:0] = pulldn_q;
      `PDSC_OFF_BC_SW:    rdata[`PDSC_BC_W-1:0] = bc_q;
      `PDSC_OFF_STATUS:
      begin
        rdata[`PDSC_STAT_ORIENT] = flip;
        rdata[`PDSC_STAT_TX] = ep_tx_i;
        rdata[`PDSC_STAT_PIN_LSB +: `PDSC_NPIN] = pin_q;
      end
      `PDSC_OFF_IRQ_STAT: rdata[`PDSC_NPIN-1:0] = irq_stat_q;
      `PDSC_OFF_IRQ_MASK: rdata[`PDSC_NPIN-1:0] = irq_mask_q;
      default:            rdata = '0;
    endcase
  end

  always_ff @(posedge sys_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      pready_o  <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o  <= '0;
    end
    else
    begin
      // An unmapped offset answers with an error and reads as zero.
      pready_o  <= setup;
      pslverr_o <= setup & ~hit;
      prdata_o  <= (setup & ~pwrite_i & hit) ? rdata : '0;
    end
  end

  always_ff @(posedge sys_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      ctrl_q     <= `PDSC_RST_CTRL;
      cmp_en_q   <= `PDSC_RST_PINS;
      pullup_q   <= `PDSC_RST_PINS;
      pulldn_q   <= `PDSC_RST_PINS;
      bc_q       <= `PDSC_RST_BC;
      irq_mask_q <= `PDSC_RST_PINS;
    end
    // Registers change only at the completing edge of an accepted write;
    // the status words are read-only.
    else if (wr)
    begin
      unique case (addr)
        `PDSC_OFF_CTRL:     ctrl_q <= pwdata_i[`PDSC_CTRL_W-1:0];
        `PDSC_OFF_CMP_EN:   cmp_en_q <= pwdata_i[`PDSC_NPIN-1:0];
        `PDSC_OFF_PULLUP:   pullup_q <= pwdata_i[`PDSC_NPIN-1:0];
        `PDSC_OFF_PULLDN:   pulldn_q <= pwdata_i[`PDSC_NPIN-1:0];
        `PDSC_OFF_BC_SW:    bc_q <= pwdata_i[`PDSC_BC_W-1:0];
        `PDSC_OFF_IRQ_MASK: irq_mask_q <= pwdata_i[`PDSC_NPIN-1:0];
        default:            ctrl_q <= ctrl_q;
      endcase
    end
  end

  // Pin sampling and edge events; a disconnected comparator is silent.
  always_ff @(posedge sys_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      pin_q <= `PDSC_RST_PINS;
    else
      pin_q <= port_in_i;
  end

  // A status read clears only the bits that it returned, so an event that
  // lands after the read data was captured stays pending.
  assign stat_shown = prdata_o[`PDSC_NPIN-1:0];
  assign stat_clr   = rd & (addr == `PDSC_OFF_IRQ_STAT);
  genvar g;
  generate
    for (g = 0; g < `PDSC_NPIN; g++)
    begin : g_evt
      assign edge_evt[g] = cmp_en_q[g] & (port_in_i[g] ^ pin_q[g]);
      assign irq_stat_d[g] = edge_evt[g]
        | (irq_stat_q[g] & ~(stat_clr & stat_shown[g]));
    end
  endgenerate

  always_ff @(posedge sys_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      irq_stat_q <= `PDSC_RST_PINS;
      irq_o      <= 1'b0;
    end
    else
    begin
      irq_stat_q <= irq_stat_d;
      // Uses the next status so that the clearing edge drops it at once.
      irq_o      <= |(irq_stat_d & irq_mask_q);
    end
  end

  // Orientation: a change opens every path for one cycle first.
  always_ff @(posedge sys_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      orient_q <= PDSC_UPSIDE_UP;
    else
      orient_q <= orient_i;
  end

  // Every path gate carries blank, so all paths stay open while the stored
  // orientation catches up with the input.
  assign flip   = (orient_q == PDSC_FLIPPED);
  assign blank  = (orient_i != orient_q);
  assign ep_en  = ctrl_q[`PDSC_CTRL_EP_EN];
  assign usb_on = ctrl_q[`PDSC_CTRL_USB_EN] & ~blank;
  assign sbu_on = ctrl_q[`PDSC_CTRL_SBU_EN] & ~blank;
  assign top_on = usb_on & ~flip;
  assign bot_on = usb_on & flip;
  assign tx_on  = ep_en & ep_tx_i;
  assign rx_pu  = ep_en & ~ep_tx_i;
  assign dcd_on = ctrl_q[`PDSC_CTRL_DCD_EN] & ~blank;
  assign chg_on = ctrl_q[`PDSC_CTRL_CHG_EN] & ~blank;

  always_comb
  begin
    out_d = '0;
    oe_d  = '0;
    out_d[`PDSC_PIN_SBU1] = flip ? sb_b_i : sb_a_i;
    out_d[`PDSC_PIN_SBU2] = flip ? sb_a_i : sb_b_i;
    oe_d[`PDSC_PIN_SBU1]  = sbu_on & sb_oe_i;
    oe_d[`PDSC_PIN_SBU2]  = sbu_on & sb_oe_i;
    out_d[`PDSC_PIN_TP]   = ep_dp_i;
    out_d[`PDSC_PIN_TN]   = ep_dm_i;
    out_d[`PDSC_PIN_BP]   = ep_dp_i;
    out_d[`PDSC_PIN_BN]   = ep_dm_i;
    oe_d[`PDSC_PIN_TP]    = top_on & tx_on;
    oe_d[`PDSC_PIN_TN]    = top_on & tx_on;
    oe_d[`PDSC_PIN_BP]    = bot_on & tx_on;
    oe_d[`PDSC_PIN_BN]    = bot_on & tx_on;
    closed = {bot_on, bot_on, top_on, top_on, sbu_on, sbu_on};
  end

  always_ff @(posedge sys_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      port_out_o    <= `PDSC_RST_PINS;
      port_oe_o     <= `PDSC_RST_PINS;
      clamp_en_o    <= `PDSC_RST_PINS;
      pullup_en_o   <= `PDSC_RST_PINS;
      pulldown_en_o <= `PDSC_RST_PINS;
      sb_a_o        <= 1'b0;
      sb_b_o        <= 1'b0;
      ep_dp_o       <= 1'b0;
      ep_dm_o       <= 1'b0;
    end
    else
    begin
      // Registered, so a flip never closes a top and a bottom path at once.
      port_out_o    <= out_d;
      port_oe_o     <= oe_d;
      clamp_en_o    <= closed;
      pullup_en_o   <= pullup_q;
      pulldown_en_o <= pulldn_q;
      // Received sideband and endpoint data come from the sampled pins.
      sb_a_o        <= flip ? pin_q[`PDSC_PIN_SBU2]
                            : pin_q[`PDSC_PIN_SBU1];
      sb_b_o        <= flip ? pin_q[`PDSC_PIN_SBU1]
                            : pin_q[`PDSC_PIN_SBU2];
      ep_dp_o       <= flip ? pin_q[`PDSC_PIN_BP]
                            : pin_q[`PDSC_PIN_TP];
      ep_dm_o       <= flip ? pin_q[`PDSC_PIN_BN]
                            : pin_q[`PDSC_PIN_TN];
    end
  end

  // Endpoint: only endpoint zero tokens are accepted, low speed only.
  always_ff @(posedge sys_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      ep_tok_ok_o              <= 1'b0;
      ep_low_speed_o           <= 1'b0;
      ep_dev_class_o           <= '0;
      endpoint_pullup_top_o    <= 1'b0;
      endpoint_pullup_bottom_o <= 1'b0;
    end
    else
    begin
      ep_tok_ok_o <= ep_en & ep_tok_vld_i
                   & (ep_tok_num_i == `PDSC_EP_ZERO);
      ep_low_speed_o           <= ep_en;
      ep_dev_class_o           <= ep_en ? `PDSC_BILLBOARD
                                        : `PDSC_CLASS_IDLE;
      endpoint_pullup_top_o    <= rx_pu & top_on;
      endpoint_pullup_bottom_o <= rx_pu & bot_on;
    end
  end

  // Charger detection: contact detect and primary/secondary detect.
  always_ff @(posedge sys_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      dplus_source_current_top_o    <= 1'b0;
      dplus_source_current_bottom_o <= 1'b0;
      dminus_pulldown_top_o         <= 1'b0;
      dminus_pulldown_bottom_o      <= 1'b0;
      detect_voltage_source_o       <= 1'b0;
      detect_current_sink_o         <= 1'b0;
      bc_force_o                    <= '0;
      bc_sink_o                     <= '0;
      bc_read_o                     <= '0;
    end
    else
    begin
      dplus_source_current_top_o    <= dcd_on & ~flip;
      dplus_source_current_bottom_o <= dcd_on & flip;
      dminus_pulldown_top_o         <= dcd_on & ~flip;
      dminus_pulldown_bottom_o      <= dcd_on & flip;
      detect_voltage_source_o       <= chg_on;
      detect_current_sink_o         <= chg_on;
      bc_force_o <= chg_on ? bc_q[`PDSC_BC_FORCE_LSB +: `PDSC_BC_FLD_W]
                           : `PDSC_BC_IDLE;
      bc_sink_o  <= chg_on ? bc_q[`PDSC_BC_SINK_LSB +: `PDSC_BC_FLD_W]
                           : `PDSC_BC_IDLE;
      bc_read_o  <= chg_on ? bc_q[`PDSC_BC_READ_LSB +: `PDSC_BC_FLD_W]
                           : `PDSC_BC_IDLE;
    end
  end

endmodule

/* tb/pdsc_cable.sv */
`timescale 1ns/1ps

module pdsc_cable
(
  input  wire logic                 clk_i,
  input  wire pdsc_pkg::pdsc_pins_t drv_i,
  input  wire pdsc_pkg::pdsc_pins_t oe_i,
  input  wire pdsc_pkg::pdsc_pins_t pu_i,
  input  wire pdsc_pkg::pdsc_pins_t pd_i,
  input  wire pdsc_pkg::pdsc_pins_t far_val_i,
  input  wire pdsc_pkg::pdsc_pins_t far_oe_i,
  output pdsc_pkg::pdsc_pins_t      pin_o
);
  import pdsc_pkg::*;
  pdsc_pins_t last_q;

  // A pin nobody drives or pulls shows the inverse of its last level.
  always_comb
  begin
    for (int i = 0; i < 6; i++)
    begin
      if (oe_i[i])
        pin_o[i] = drv_i[i];
      else if (far_oe_i[i])
        pin_o[i] = far_val_i[i];
      else if (pu_i[i] | pd_i[i])
        pin_o[i] = pu_i[i];
      else
        pin_o[i] = ~last_q[i];
    end
  end

  always_ff @(posedge clk_i)
  begin
    last_q <= pin_o;
  end
endmodule

/* tb/pdsc_chk.sv */
`timescale 1ns/1ps

module pdsc_chk
(
  // Clock, reset and bus.
  input wire logic                   sys_clk_i,
  input wire logic                   arst_n_i,
  input wire logic                   psel_i,
  input wire logic                   penable_i,
  input wire logic                   pready_o,
  // Orientation and pins.
  input wire pdsc_pkg::pdsc_orient_t orient_i,
  input wire pdsc_pkg::pdsc_pins_t   port_oe_o,
  input wire pdsc_pkg::pdsc_pins_t   clamp_en_o,
  // Endpoint.
  input wire logic                   ep_tx_i,
  input wire logic                   ep_tok_vld_i,
  input wire logic [3:0]             ep_tok_num_i,
  input wire logic                   ep_tok_ok_o,
  input wire logic                   ep_low_speed_o,
  input wire logic [7:0]             ep_dev_class_o,
  input wire logic                   endpoint_pullup_top_o,
  input wire logic                   endpoint_pullup_bottom_o,
  // Charger detection.
  input wire logic                   dplus_source_current_top_o,
  input wire logic                   dplus_source_current_bottom_o,
  input wire logic                   dminus_pulldown_top_o,
  input wire logic                   dminus_pulldown_bottom_o,
  input wire logic                   detect_voltage_source_o,
  input wire logic                   detect_current_sink_o
);
  import pdsc_pkg::*;

  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!arst_n_i);

  a_apb_wait: assert property ($rose(penable_i) && psel_i |=> pready_o)
    else $error("pready late");
  a_apb_pulse: assert property (pready_o |=> !pready_o)
    else $error("pready held");
  a_tx_pullup: assert property (ep_tx_i |=> !endpoint_pullup_top_o
    && !endpoint_pullup_bottom_o) else $error("pullup in transmit");
  a_pullup_top: assert property (endpoint_pullup_top_o |->
    !endpoint_pullup_bottom_o && $past(orient_i) == PDSC_UPSIDE_UP)
    else $error("top pullup wrong");
  a_pullup_bot: assert property (endpoint_pullup_bottom_o |->
    $past(orient_i) == PDSC_FLIPPED) else $error("bottom pullup wrong");
  a_dcd_side: assert property (dplus_source_current_top_o |->
    !dplus_source_current_bottom_o && $past(orient_i) == PDSC_UPSIDE_UP)
    else $error("source side wrong");
  a_dcd_pair: assert property (
    dminus_pulldown_top_o == dplus_source_current_top_o &&
    dminus_pulldown_bottom_o == dplus_source_current_bottom_o)
    else $error("pulldown not with source");
  a_det_pair: assert property (
    detect_voltage_source_o == detect_current_sink_o)
    else $error("source not with sink");
  a_orient_break: assert property (!$stable(orient_i) |=>
    clamp_en_o == '0 && port_oe_o == '0 && !endpoint_pullup_top_o &&
    !endpoint_pullup_bottom_o && !dplus_source_current_bottom_o &&
    !dplus_source_current_top_o && !detect_voltage_source_o)
    else $error("no break on flip");
  a_tok_ep0: assert property (ep_tok_ok_o |-> $past(ep_tok_vld_i) &&
    $past(ep_tok_num_i) == 4'h0 && ep_low_speed_o &&
    ep_dev_class_o == 8'h11) else $error("bad token answer");
endmodule

bind pdsc_top pdsc_chk i_chk (.*);

/* tb/tb.sv */
`timescale 1ns/1ps

module tb;
  import pdsc_pkg::*;
  logic sys_clk_i, arst_n_i, psel_i, penable_i, pwrite_i;
  logic pready_o, pslverr_o, irq_o;
  logic [31:0] paddr_i, pwdata_i, prdata_o, r;
  logic e;
  pdsc_orient_t orient_i;
  pdsc_pins_t port_in_i, port_out_o, port_oe_o, clamp_en_o;
  pdsc_pins_t pullup_en_o, pulldown_en_o, ext_val, ext_oe;
  pdsc_usb_t bc_force_o, bc_sink_o, bc_read_o;
  logic sb_a_i, sb_b_i, sb_oe_i, sb_a_o, sb_b_o;
  logic ep_tx_i, ep_dp_i, ep_dm_i, ep_tok_vld_i, ep_dp_o, ep_dm_o;
  logic [3:0] ep_tok_num_i;
  logic [7:0] ep_dev_class_o;
  logic ep_tok_ok_o, ep_low_speed_o;
  logic endpoint_pullup_top_o, endpoint_pullup_bottom_o;
  logic dplus_source_current_top_o, dplus_source_current_bottom_o;
  logic dminus_pulldown_top_o, dminus_pulldown_bottom_o;
  logic detect_voltage_source_o, detect_current_sink_o;
  int fail_count = 0;
  int tests_run = 0;
  logic [31:0] msk [8] = '{32'h1F, 32'h3F, 32'h3F, 32'h3F, 32'hFFF,
                           32'h0, 32'h0, 32'h3F};

  pdsc_top i_dut (.*);
  pdsc_cable i_cable (.clk_i(sys_clk_i), .drv_i(port_out_o),
    .oe_i(port_oe_o), .pu_i(pullup_en_o), .pd_i(pulldown_en_o),
    .far_val_i(ext_val), .far_oe_i(ext_oe), .pin_o(port_in_i));

  initial
  begin
    sys_clk_i = 1'b0;
    forever #2 sys_clk_i = ~sys_clk_i;
  end

  task finish_test;
    $display("tests_run=%0d fail_count=%0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task chk(input logic [31:0] s, input logic [31:0] x);
    tests_run++;
    if (s !== x)
    begin
      fail_count++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, s, x);
    end
  endtask

  task tick(input int n);
    repeat (n) @(posedge sys_clk_i);
  endtask

  // One APB transfer; entered and left just after a rising edge.
  task apb(input logic w, input logic [31:0] a, input logic [31:0] d);
    int n;
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge sys_clk_i);
    penable_i <= 1'b1;
    n = 0;
    do
    begin
      @(posedge sys_clk_i);
      n++;
    end
    while (pready_o !== 1'b1 && n < 20);
    if (n >= 20)
    begin
      fail_count++;
      finish_test();
    end
    r = prdata_o;
    e = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
    @(posedge sys_clk_i);
  endtask

  task wr(input logic [31:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task rd(input logic [31:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    chk(r, x);
  endtask

  initial
  begin
    {psel_i, penable_i, pwrite_i, sb_a_i, sb_b_i, sb_oe_i} = '0;
    {ep_tx_i, ep_dp_i, ep_dm_i, ep_tok_vld_i, ep_tok_num_i} = '0;
    {paddr_i, pwdata_i, ext_val} = '0;
    orient_i = PDSC_UPSIDE_UP;
    ext_oe = 6'h3F;
    arst_n_i = 1'b0;
    tick(16);
    arst_n_i <= 1'b1;
    tick(1);
    for (int i = 0; i < 8; i++)
    begin
      rd(i * 4, 32'h0);
      wr(i * 4, 32'hFFFFFFFF);
      rd(i * 4, msk[i]);
      wr(i * 4, 32'h0);
    end
    rd(32'h20, 32'h0);
    chk(e, 1'b1);
    wr(32'h22, 32'h1);
    chk(e, 1'b1);
    ext_oe <= 6'h3E;
    wr(32'h08, 32'h2B);
    wr(32'h0C, 32'h14);
    tick(3);
    chk(pullup_en_o, 6'h2B);
    chk(pulldown_en_o, 6'h14);
    rd(32'h14, 32'h100);
    ext_oe <= 6'h3F;
    wr(32'h08, 32'h0);
    wr(32'h0C, 32'h0);
    wr(32'h1C, 32'h4);
    wr(32'h04, 32'hC);
    ext_val <= 6'h04;
    tick(4);
    chk(irq_o, 1'b1);
    rd(32'h18, 32'h4);
    tick(2);
    chk(irq_o, 1'b0);
    ext_val <= 6'h0C;
    tick(4);
    chk(irq_o, 1'b0);
    rd(32'h18, 32'h8);
    wr(32'h04, 32'h0);
    ext_val <= 6'h2C;
    tick(4);
    rd(32'h18, 32'h0);
    ext_val <= 6'h00;
    wr(32'h00, 32'h11);
    tick(3);
    chk(endpoint_pullup_top_o, 1'b1);
    chk(ep_dev_class_o, 8'h11);
    ep_tok_vld_i <= 1'b1;
    tick(1);
    ep_tok_vld_i <= 1'b0;
    tick(1);
    chk(ep_tok_ok_o, 1'b1);
    ep_tok_vld_i <= 1'b1;
    ep_tok_num_i <= 4'h1;
    tick(1);
    ep_tok_vld_i <= 1'b0;
    tick(1);
    chk(ep_tok_ok_o, 1'b0);
    chk(ep_low_speed_o, 1'b1);
    orient_i <= PDSC_FLIPPED;
    tick(4);
    chk(endpoint_pullup_bottom_o, 1'b1);
    ep_tx_i <= 1'b1;
    ep_dp_i <= 1'b1;
    tick(3);
    chk(endpoint_pullup_bottom_o, 1'b0);
    chk(port_oe_o, 6'h30);
    chk(port_out_o & 6'h30, 6'h10);
    chk(clamp_en_o, 6'h30);
    orient_i <= PDSC_UPSIDE_UP;
    tick(4);
    chk(port_oe_o, 6'h0C);
    ep_tx_i <= 1'b0;
    wr(32'h00, 32'h2);
    tick(3);
    chk(dplus_source_current_top_o, 1'b1);
    chk(dminus_pulldown_top_o, 1'b1);
    orient_i <= PDSC_FLIPPED;
    tick(4);
    chk(dplus_source_current_bottom_o, 1'b1);
    wr(32'h00, 32'h4);
    wr(32'h10, 32'hC21);
    tick(3);
    chk({bc_read_o, bc_sink_o, bc_force_o}, 12'hC21);
    chk(detect_voltage_source_o, 1'b1);
    wr(32'h00, 32'h8);
    sb_oe_i <= 1'b1;
    sb_a_i <= 1'b1;
    tick(3);
    chk(bc_force_o, 4'h0);
    chk(port_out_o & 6'h03, 6'h02);
    orient_i <= PDSC_UPSIDE_UP;
    tick(4);
    chk(port_out_o & 6'h03, 6'h01);
    sb_oe_i <= 1'b0;
    ext_val <= 6'h01;
    tick(4);
    chk({sb_b_o, sb_a_o}, 2'b01);
    orient_i <= PDSC_FLIPPED;
    tick(4);
    chk({sb_b_o, sb_a_o}, 2'b10);
    ext_val <= 6'h24;
    tick(3);
    chk({ep_dm_o, ep_dp_o}, 2'b10);
    finish_test();
  end
endmodule
